// ---- rtl/pex_pkg.sv ----
// Purpose: shared constants and types of the i2c port expander
// Assumes: eight port pins, 7-bit slave address
// Notes:   register selects are the two low pointer bits
`default_nettype none
package pex_pkg;
  // register pointer codes
  localparam logic [1:0] REG_IN  = 2'h0;
  localparam logic [1:0] REG_OUT = 2'h1;
  localparam logic [1:0] REG_POL = 2'h2;
  localparam logic [1:0] REG_DIR = 2'h3;
  // fixed upper address nibble
  localparam logic [3:0] ADDR_HI = 4'h4;
  // register reset values
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  // bit count reached after a full byte
  localparam logic [3:0] BYTE_END = 4'h8;
  // settle cycles before the input snapshot is trusted
  localparam logic [1:0] INIT_CYC = 2'h3;
  // byte kinds within a transfer
  localparam logic [1:0] BK_ADDR = 2'h0;
  localparam logic [1:0] BK_CMD  = 2'h1;
  localparam logic [1:0] BK_DATA = 2'h2;
  // bus engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_SACK = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } pex_st_e;
  // software visible configuration
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] pol;
    logic [7:0] dir;
  } pex_cfg_s;
endpackage
`default_nettype wire

// ---- rtl/pex_top.sv ----
// Purpose: i2c slave driving an 8-bit parallel port
// Assumes: link_clk oversamples scl and sda
// Notes:   registers live on link_clk, port logic on sys_clk
`default_nettype none
module pex_top (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       link_clk,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       addr_strap_bit0,
  input  wire logic       addr_strap_bit1,
  input  wire logic       addr_strap_bit2,
  input  wire logic [7:0] port_pins_i,
  output logic      [7:0] port_pins_o,
  output logic      [7:0] port_pins_oe,
  output logic            int_n_o,
  output logic            int_n_oe
);
  // link domain reset, async assert, sync release
  logic [1:0]       lrst_q;
  logic             lrst;
  // bus line synchronisers and edge history
  logic [1:0]       scl_y_q;
  logic [1:0]       sda_y_q;
  logic             scl_p_q;
  logic             sda_p_q;
  logic             scl_s;
  logic             sda_s;
  logic             rise;
  logic             fall;
  logic             start;
  logic             stop;
  // strap and input level crossings
  logic [2:0]       strap_m_q;
  logic [2:0]       strap_q;
  logic [7:0]       in_m_q;
  logic [7:0]       in_l_q;
  // bus engine
  pex_pkg::pex_st_e st_q;
  logic [3:0]       bit_q;
  logic [7:0]       sh_q;
  logic [1:0]       kind_q;
  logic             rw_q;
  logic             oe_q;
  logic             mack_q;
  logic [1:0]       ptr_q;
  pex_pkg::pex_cfg_s cfg_q;
  logic             clr_t_q;
  logic             cfg_t_q;     // configuration write toggle
  logic             rx_done;
  logic             hit;
  logic             cmd_wr;
  logic             dat_wr;
  logic             in_rd;
  logic [7:0]       tx_byte;
  // sys domain
  logic [7:0]       pin_m_q;
  logic [7:0]       live_q;
  logic [2:0]       cfg_s_q;     // write toggle synchroniser
  logic             cfg_ev;      // configuration word may be taken
  pex_pkg::pex_cfg_s cfg_y_q;
  logic [2:0]       clr_y_q;
  logic             clr_ev;
  logic [1:0]       init_q;
  logic             ready;
  logic [7:0]       snap_q;
  logic             int_q;
  logic [7:0]       pin_o_q;
  logic [7:0]       pin_oe_q;

  // link reset synchroniser
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst) lrst_q <= 2'h3;
    else     lrst_q <= {lrst_q[0], 1'b0};
  end
  assign lrst = lrst_q[1];

  // bus lines: two flops then one of history
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
    begin
      scl_y_q <= 2'h3;
      sda_y_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_y_q <= {scl_y_q[0], scl_i};
      sda_y_q <= {sda_y_q[0], sda_i};
      scl_p_q <= scl_y_q[1];
      sda_p_q <= sda_y_q[1];
    end
  end
  assign scl_s = scl_y_q[1];
  assign sda_s = sda_y_q[1];
  assign rise  = scl_s & ~scl_p_q;
  assign fall  = ~scl_s & scl_p_q;
  // sda moving while scl stays high is start or stop
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // straps and pin levels synchronised straight from the pins,
  // so no multi-bit word crosses from the system clock
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
    begin
      strap_m_q <= 3'h0;
      strap_q   <= 3'h0;
      in_m_q    <= 8'h00;
      in_l_q    <= 8'h00;
    end
    else
    begin
      // straps assumed steady inside a transfer
      strap_m_q <= {addr_strap_bit2, addr_strap_bit1,
                    addr_strap_bit0};
      strap_q   <= strap_m_q;
      in_m_q    <= port_pins_i;
      in_l_q    <= in_m_q;
    end
  end

  // byte events
  assign rx_done = (st_q == pex_pkg::ST_RX) && fall &&
                   (bit_q == pex_pkg::BYTE_END);
  assign hit     = (sh_q[7:1] == {pex_pkg::ADDR_HI, strap_q});
  assign cmd_wr  = rx_done && (kind_q == pex_pkg::BK_CMD);
  assign dat_wr  = rx_done && (kind_q == pex_pkg::BK_DATA);
  assign in_rd   = (st_q == pex_pkg::ST_MACK) && rise &&
                   (ptr_q == pex_pkg::REG_IN);

  // read data mux
  always_comb
  begin
    case (ptr_q)
      pex_pkg::REG_IN:  tx_byte = in_l_q ^ cfg_q.pol;
      pex_pkg::REG_OUT: tx_byte = cfg_q.out;
      pex_pkg::REG_POL: tx_byte = cfg_q.pol;
      default:          tx_byte = cfg_q.dir;
    endcase
  end

  // bus engine: framing, ack and shifting
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
    begin
      st_q   <= pex_pkg::ST_IDLE;
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      kind_q <= pex_pkg::BK_ADDR;
      rw_q   <= 1'b0;
      oe_q   <= 1'b0;
      mack_q <= 1'b0;
    end
    else if (start)
    begin
      // start or repeated start begins a new address byte
      st_q   <= pex_pkg::ST_RX;
      bit_q  <= 4'h0;
      kind_q <= pex_pkg::BK_ADDR;
      oe_q   <= 1'b0;
    end
    else if (stop)
    begin
      st_q <= pex_pkg::ST_IDLE;
      oe_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        pex_pkg::ST_RX:
        begin
          // shift in msb first on scl rise
          if (rise)
          begin
            sh_q  <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end
          else if (rx_done)
          begin
            bit_q <= 4'h0;
            if (kind_q != pex_pkg::BK_ADDR)
            begin
              st_q <= pex_pkg::ST_SACK;
              oe_q <= 1'b1;
            end
            else if (hit)
            begin
              st_q <= pex_pkg::ST_SACK;
              oe_q <= 1'b1;
              rw_q <= sh_q[0];
            end
            else
              st_q <= pex_pkg::ST_IDLE;
          end
        end
        pex_pkg::ST_SACK:
        begin
          // ack held low through the ninth clock
          if (fall)
          begin
            bit_q <= 4'h0;
            if (rw_q)
            begin
              // read: no pointer byte, send data at once
              st_q <= pex_pkg::ST_TX;
              sh_q <= tx_byte;
              oe_q <= ~tx_byte[7];
            end
            else
            begin
              st_q <= pex_pkg::ST_RX;
              oe_q <= 1'b0;
              if (kind_q == pex_pkg::BK_ADDR)
                kind_q <= pex_pkg::BK_CMD;
              else
                kind_q <= pex_pkg::BK_DATA;
            end
          end
        end
        pex_pkg::ST_TX:
        begin
          // bits change on scl fall, counted on rise
          if (rise)
            bit_q <= bit_q + 4'h1;
          else if (fall)
          begin
            if (bit_q == pex_pkg::BYTE_END)
            begin
              st_q <= pex_pkg::ST_MACK;
              oe_q <= 1'b0;
            end
            else
            begin
              sh_q <= {sh_q[6:0], 1'b1};
              oe_q <= ~sh_q[6];
            end
          end
        end
        pex_pkg::ST_MACK:
        begin
          // sample master ack, nack leaves sda released
          if (rise)
            mack_q <= ~sda_s;
          else if (fall)
          begin
            bit_q <= 4'h0;
            if (mack_q)
            begin
              st_q <= pex_pkg::ST_TX;
              sh_q <= tx_byte;
              oe_q <= ~tx_byte[7];
            end
            else
              st_q <= pex_pkg::ST_IDLE;
          end
        end
        default: ; // idle waits for start
      endcase
    end
  end
  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  // register pointer and writable registers
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
    begin
      ptr_q   <= pex_pkg::REG_IN;
      cfg_q.out <= pex_pkg::OUT_RST;
      cfg_q.pol <= pex_pkg::POL_RST;
      cfg_q.dir <= pex_pkg::DIR_RST;
    end
    else if (cmd_wr)
      ptr_q <= sh_q[1:0];
    else if (dat_wr)
    begin
      // writes to the input register fall through
      case (ptr_q)
        pex_pkg::REG_OUT: cfg_q.out <= sh_q;
        pex_pkg::REG_POL: cfg_q.pol <= sh_q;
        pex_pkg::REG_DIR: cfg_q.dir <= sh_q;
        default: ;
      endcase
    end
  end

  // input read event as a toggle toward sys_clk
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)       clr_t_q <= 1'b0;
    else if (in_rd) clr_t_q <= ~clr_t_q;
  end

  // configuration write event as a toggle toward sys_clk
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)        cfg_t_q <= 1'b0;
    else if (dat_wr) cfg_t_q <= ~cfg_t_q;
  end

  // pins and configuration into sys domain
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_m_q <= 8'h00;
      live_q  <= 8'h00;
      cfg_s_q <= 3'h0;
      clr_y_q <= 3'h0;
    end
    else
    begin
      pin_m_q <= port_pins_i;
      live_q  <= pin_m_q;
      cfg_s_q <= {cfg_s_q[1:0], cfg_t_q};
      clr_y_q <= {clr_y_q[1:0], clr_t_q};
    end
  end
  assign clr_ev = clr_y_q[2] ^ clr_y_q[1];
  assign cfg_ev = cfg_s_q[2] ^ cfg_s_q[1];

  // configuration word taken only once its write toggle has crossed,
  // so every bit has long settled when it is sampled
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)         cfg_y_q <= {pex_pkg::OUT_RST, pex_pkg::POL_RST,
                                 pex_pkg::DIR_RST};
    else if (cfg_ev) cfg_y_q <= cfg_q;
  end
  assign ready  = (init_q == pex_pkg::INIT_CYC);

  // settle counter before the snapshot is trusted
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)        init_q <= 2'h0;
    else if (!ready) init_q <= init_q + 2'h1;
  end

  // snapshot of input levels, refreshed on input read
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)                   snap_q <= 8'h00;
    else if (!ready || clr_ev) snap_q <= live_q;
  end

  // interrupt: any input pin differing from snapshot
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst) int_q <= 1'b0;
    else     int_q <= ready &&
                      (|((live_q ^ snap_q) & cfg_y_q.dir));
  end
  // open drain: only ever pulls low
  assign int_n_o  = 1'b0;
  assign int_n_oe = int_q;

  // per pin drivers: high side or low side, or both off
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          pin_o_q[gi]  <= 1'b1;
          pin_oe_q[gi] <= 1'b0;
        end
        else
        begin
          pin_o_q[gi]  <= cfg_y_q.out[gi];
          pin_oe_q[gi] <= ~cfg_y_q.dir[gi];
        end
      end
    end
  endgenerate
  assign port_pins_o  = pin_o_q;
  assign port_pins_oe = pin_oe_q;

  // checks on the port side
  property p_hiz;
    @(posedge sys_clk) disable iff (rst)
    ##1 ((port_pins_oe & $past(cfg_y_q.dir)) == 8'h00);
  endproperty
  a_hiz: assert property (p_hiz) else $error("input pin driven");
  property p_drv;
    @(posedge sys_clk) disable iff (rst)
    (cfg_y_q.dir == 8'h00) |=> (port_pins_o == $past(cfg_y_q.out));
  endproperty
  a_drv: assert property (p_drv) else $error("output level wrong");
  property p_int_set;
    @(posedge sys_clk) disable iff (rst)
    (ready && ((live_q ^ snap_q) & cfg_y_q.dir) != 8'h00) |=> int_n_oe;
  endproperty
  a_int_set: assert property (p_int_set) else $error("int missed");
  property p_int_clr;
    @(posedge sys_clk) disable iff (rst)
    (((live_q ^ snap_q) & cfg_y_q.dir) == 8'h00) |=> !int_n_oe;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("int stuck");
  property p_snap;
    @(posedge sys_clk) disable iff (rst)
    (ready && clr_ev) ##1 $stable(live_q) |=> !int_n_oe;
  endproperty
  a_snap: assert property (p_snap) else $error("read clear lost");

  // checks on the bus side
  property p_start;
    @(posedge link_clk) disable iff (lrst)
    start |=> (st_q == pex_pkg::ST_RX) && (bit_q == 4'h0) && !sda_oe;
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_stop;
    @(posedge link_clk) disable iff (lrst)
    stop |=> (st_q == pex_pkg::ST_IDLE) && !sda_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
  property p_ack;
    @(posedge link_clk) disable iff (lrst)
    (rx_done && kind_q == pex_pkg::BK_ADDR && hit && !start && !stop)
    |=> sda_oe && (st_q == pex_pkg::ST_SACK);
  endproperty
  a_ack: assert property (p_ack) else $error("address not acked");
  property p_rel;
    @(posedge link_clk) disable iff (lrst)
    (st_q == pex_pkg::ST_MACK) |-> !sda_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("sda held in master ack");
  property p_ptr;
    @(posedge link_clk) disable iff (lrst)
    !cmd_wr |=> $stable(ptr_q);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer changed");
endmodule // pex_top
`default_nettype wire

// ---- rtl/unused_placeholder_none.sv ----
`default_nettype none
`default_nettype wire

// ---- tb/pex_i2c_master.sv ----
// Purpose: i2c bus master model facing the expander
// Assumes: the slave never stretches scl
// Notes:   bit phases are counted on sys_clk
`default_nettype none
module pex_i2c_master (
  input  wire logic sys_clk,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 12;  // phase length, above 4 link_clk
  // bus idles released, pull-ups give high
  initial
  begin
    scl_o = 1'b1;
    sda_pull = 1'b0;
  end
  // one phase of the bus clock
  task automatic gap();
    repeat (HALF) @(posedge sys_clk);
  endtask
  // sda set in low phase, held through high, sampled late
  task automatic bit_cell(input logic b, output logic r);
    sda_pull <= ~b;
    gap();
    scl_o <= 1'b1;
    gap();
    r = sda_i;
    scl_o <= 1'b0;
    gap();
  endtask
  // start or repeated start
  task automatic start();
    sda_pull <= 1'b0;
    gap();
    scl_o <= 1'b1;
    gap();
    sda_pull <= 1'b1;
    gap();
    scl_o <= 1'b0;
    gap();
  endtask
  // stop, entered with scl low
  task automatic stop();
    sda_pull <= 1'b1;
    gap();
    scl_o <= 1'b1;
    gap();
    sda_pull <= 1'b0;
    gap();
  endtask
  // byte out msb first, then sda released for the ack
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_cell(d[i], r);
    bit_cell(1'b1, r);
    ack = ~r;
  endtask
  // byte in, then ack, or nack on the last one
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cell(1'b1, r);
      d[i] = r;
    end
    bit_cell(last, r);
  endtask
endmodule  // pex_i2c_master
`default_nettype wire

// ---- tb/pex_top_test.sv ----
// Purpose: self-checking bench of the i2c port expander
// Assumes: pull-ups on sda, interrupt line and port pins
// Notes:   straps only change between stop and start
`default_nettype none
module pex_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk;       // 50 MHz
  logic       link_clk;      // 30 ns, own phase
  logic       rst;           // async, active high
  logic       scl;           // bus clock from master
  logic       m_pull;        // master pulls sda low
  logic       sda;           // resolved sda level
  logic       sda_o;
  logic       sda_oe;
  logic [2:0] straps;        // address straps
  logic [7:0] ext_lvl;       // external levels on pins
  logic [7:0] pins;          // resolved pin levels
  logic [7:0] port_pins_o;
  logic [7:0] port_pins_oe;
  logic       int_n_o;
  logic       int_n_oe;
  logic [7:0] out_v;         // expected register contents
  logic [7:0] dir_v;
  logic [7:0] pol_v;
  logic       a;             // last ack seen
  int         errors;
  int         n_compared;
  // open-drain sda, pins driven or left to the outside
  assign sda  = ~m_pull & (~sda_oe | sda_o);
  assign pins = (port_pins_oe & port_pins_o) | (~port_pins_oe & ext_lvl);
  // system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // link clock, unrelated phase
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  pex_top i_pex_top (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .link_clk        (link_clk),
    .scl_i           (scl),
    .sda_i           (sda),
    .sda_o           (sda_o),
    .sda_oe          (sda_oe),
    .addr_strap_bit0 (straps[0]),
    .addr_strap_bit1 (straps[1]),
    .addr_strap_bit2 (straps[2]),
    .port_pins_i     (pins),
    .port_pins_o     (port_pins_o),
    .port_pins_oe    (port_pins_oe),
    .int_n_o         (int_n_o),
    .int_n_oe        (int_n_oe)
  );
  pex_i2c_master i_pex_i2c_master (
    .sys_clk  (sys_clk),
    .sda_i    (sda),
    .scl_o    (scl),
    .sda_pull (m_pull)
  );
  // expected input register value
  function automatic logic [7:0] pins_exp();
    return ((~dir_v & out_v) | (dir_v & ext_lvl)) ^ pol_v;
  endfunction
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // byte out and ack compare
  task automatic sb(input logic [7:0] d, input logic ack);
    i_pex_i2c_master.send_byte(d, a);
    chk({7'h0, a}, {7'h0, ack});
  endtask
  // transfer to another slave address
  task automatic foreign();
    i_pex_i2c_master.start();
    sb({pex_pkg::ADDR_HI, straps ^ 3'h2, 1'b0}, 1'b0);
    i_pex_i2c_master.stop();
  endtask
  // register write: address, pointer, one data byte
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    i_pex_i2c_master.start();
    sb({pex_pkg::ADDR_HI, straps, 1'b0}, 1'b1);
    sb(ptr, 1'b1);
    sb(d, 1'b1);
    i_pex_i2c_master.stop();
  endtask
  // register read of n bytes, pointer set first if asked
  task automatic rd(input logic setp, input logic [7:0] ptr,
                    input logic [7:0] exp, input int n);
    logic [7:0] d;
    i_pex_i2c_master.start();
    if (setp)
    begin
      sb({pex_pkg::ADDR_HI, straps, 1'b0}, 1'b1);
      sb(ptr, 1'b1);
      i_pex_i2c_master.start();
    end
    sb({pex_pkg::ADDR_HI, straps, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      i_pex_i2c_master.get_byte(i == n - 1, d);
      chk(d, exp);
    end
    i_pex_i2c_master.stop();
    chk({7'h0, sda_oe}, 8'h00);
  endtask
  // bounded wait for the interrupt level
  task automatic wait_int(input logic exp);
    int k;
    k = 0;
    while (int_n_oe !== exp && k < 40)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk({7'h0, int_n_oe}, {7'h0, exp});
  endtask
  // watchdog against a hung bus
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    straps = 3'h5;
    ext_lvl = 8'ha5;
    out_v = pex_pkg::OUT_RST;
    dir_v = pex_pkg::DIR_RST;
    pol_v = pex_pkg::POL_RST;
    errors = 0;
    n_compared = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk(port_pins_oe, 8'h00);
    chk({6'h0, int_n_o, int_n_oe}, 8'h00);
    rd(1'b0, 8'h00, pins_exp(), 1);
    rd(1'b1, 8'h01, pex_pkg::OUT_RST, 1);
    rd(1'b1, 8'h02, pex_pkg::POL_RST, 1);
    rd(1'b1, 8'h03, pex_pkg::DIR_RST, 1);
    // every strap value: own address acked, one other address not
    for (int s = 0; s < 8; s++)
    begin
      straps <= 3'(s);
      repeat (4) @(posedge sys_clk);
      i_pex_i2c_master.start();
      sb({pex_pkg::ADDR_HI, straps, 1'b0}, 1'b1);
      i_pex_i2c_master.stop();
      foreign();
    end
    // output register, then half the pins made outputs
    wr(8'hfd, 8'h3c);
    out_v = 8'h3c;
    chk(port_pins_oe, 8'h00);
    wr(8'h03, 8'h0f);
    dir_v = 8'h0f;
    chk(port_pins_oe, ~dir_v);
    chk(port_pins_o & port_pins_oe, out_v & ~dir_v);
    chk({7'h0, int_n_oe}, 8'h00);
    rd(1'b1, 8'h01, out_v, 2);
    wr(8'h00, 8'h55);
    rd(1'b0, 8'h00, pins_exp(), 1);
    wr(8'h02, 8'h0f);
    pol_v = 8'h0f;
    rd(1'b1, 8'h00, pins_exp(), 2);
    rd(1'b0, 8'h00, pins_exp(), 1);
    // interrupt: set, return, foreign traffic, read clear
    ext_lvl <= ext_lvl ^ 8'h01;
    wait_int(1'b1);
    ext_lvl <= ext_lvl ^ 8'h01;
    wait_int(1'b0);
    ext_lvl <= ext_lvl ^ 8'h02;
    wait_int(1'b1);
    foreign();
    chk({7'h0, int_n_oe}, 8'h01);
    rd(1'b0, 8'h00, pins_exp(), 1);
    chk({7'h0, int_n_oe}, 8'h00);
    ext_lvl <= ext_lvl ^ 8'h04;
    wait_int(1'b1);
    rd(1'b0, 8'h00, pins_exp(), 1);
    chk({7'h0, int_n_oe}, 8'h00);
    // output pins toggle without interrupt
    wr(8'h01, 8'hc3);
    out_v = 8'hc3;
    repeat (10) @(posedge sys_clk);
    chk({7'h0, int_n_oe}, 8'h00);
    // every pin an output follows the output register
    wr(8'h03, 8'h00);
    dir_v = 8'h00;
    chk(port_pins_oe, 8'hff);
    chk(port_pins_o, out_v);
    chk({7'h0, int_n_oe}, 8'h00);
    rd(1'b1, 8'h00, pins_exp(), 1);
    // outputs back to inputs with differing levels
    wr(8'h03, 8'hff);
    dir_v = 8'hff;
    wait_int(1'b1);
    chk(port_pins_oe, 8'h00);
    rd(1'b1, 8'h00, pins_exp(), 1);
    chk({7'h0, int_n_oe}, 8'h00);
    print_verdict();
  end
endmodule  // pex_top_test
`default_nettype wire
